/* dv/rms_far_side.sv */
`default_nettype none
// Reset source and coprocessor seen from the shared pin side.
module rms_far_side
(
    // Commands from the bench.
    input wire logic i_clk,
    input wire logic i_fire,
    input wire logic i_drv_en,
    input wire logic i_drv_val,
    input wire logic i_fb_en,
    input wire logic i_fb,
    // Pins toward the block.
    output logic o_init_n,
    output logic o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    // Init stays low 12 clocks, well over four clock-output cycles.
    always @(posedge i_clk)
        cnt <= i_fire ? 4'hC : cnt - {3'h0, cnt != 4'h0};
    assign o_init_n = cnt == 4'h0;
    // Undriven pin reads high, as the pull-up would hold it.
    assign o_pin = i_fb_en ? i_fb : (i_drv_en ? i_drv_val : 1'b1);
endmodule // rms_far_side
`default_nettype wire

/* dv/rms_top_props.sv */
`default_nettype none
// Port checks for the sequencer; all of them share one clock.
module rms_top_props
(
    // Inputs of the block.
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_hw_init_request_n,
    input wire logic i_strap_pin,
    input wire logic i_wait_start,
    input wire logic i_irq_pending,
    input wire logic i_irq_enable,
    // Outputs of the block.
    input wire logic o_system_clock_output,
    input wire logic o_sys_init,
    input wire logic o_core_dormant,
    input wire logic o_fetch_start,
    input wire logic o_mode_enhanced,
    input wire logic o_wait_halted,
    input wire logic o_irq_service,
    input wire logic o_coproc_busy,
    input wire logic o_strap_pullup_en
);
    timeunit 1ns;
    timeprecision 1ps;
    // Power-on reset masks every check; clk_runs_a also skips the first edge after it.
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    clk_runs_a:
    assert property ($past(i_rst_n) |-> o_system_clock_output
        != $past(o_system_clock_output)) else $error("clock stalled");
    init_holds_a:
    assert property (!i_hw_init_request_n [*7] |-> o_core_dormant
        && o_sys_init) else $error("not dormant in init");
    fetch_time_a:
    assert property ($rose(i_hw_init_request_n) |-> ##[14:19] o_fetch_start)
        else $error("fetch late");
    init_tail_a:
    assert property ($rose(i_hw_init_request_n) |-> o_sys_init [*4]
        ##[2:8] !o_sys_init) else $error("init output length");
    mode_hold_a:
    assert property (o_mode_enhanced != $past(o_mode_enhanced)
        |-> o_core_dormant) else $error("mode changed in run");
    poll_halt_a:
    assert property (i_wait_start && !o_wait_halted && !o_mode_enhanced
        && $past(i_strap_pin, 3) && $past(i_strap_pin, 4)
        && $past(i_hw_init_request_n, 3) && $past(i_hw_init_request_n, 4)
        |=> o_wait_halted) else $error("no halt");
    poll_release_a:
    assert property (!i_strap_pin [*8] |-> ##2 !o_wait_halted)
        else $error("halt kept");
    irq_serve_a:
    assert property (o_irq_service |-> $past(i_irq_pending && i_irq_enable))
        else $error("stray service");
    busy_follow_a:
    assert property (i_strap_pin [*5] ##0 (o_mode_enhanced
        && $past(i_hw_init_request_n, 3) && $past(i_hw_init_request_n, 4))
        |=> o_coproc_busy) else $error("busy missed");
endmodule // rms_top_props
bind rms_top rms_top_props props_u (.*);
`default_nettype wire

/* dv/test_reset_and_mode_select.sv */
`default_nettype none
// Each scenario task (modes, poll, coproc) drives its stimulus and judges it before it returns.
module test_reset_and_mode_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_wait_start = 1'b0, fire = 1'b1;
    logic i_irq_pending = 1'b0, i_irq_enable = 1'b0, fb_en = 1'b0;
    logic drv_en = 1'b0, drv_val = 1'b0, init_n, pin, sclk, sinit;
    logic dorm, fetch, mode, halt, srv, busy, pull;
    int err_total = 0, checks = 0;
    rms_far_side far_u (.i_clk, .i_fire(fire), .i_drv_en(drv_en),
        .i_drv_val(drv_val), .i_fb_en(fb_en), .i_fb(sinit),
        .o_init_n(init_n), .o_pin(pin));
    rms_top dut_u (.i_clk, .i_rst_n, .i_hw_init_request_n(init_n),
        .i_strap_pin(pin), .i_wait_start, .i_irq_pending, .i_irq_enable,
        .o_system_clock_output(sclk), .o_sys_init(sinit),
        .o_core_dormant(dorm), .o_fetch_start(fetch), .o_mode_enhanced(mode),
        .o_wait_halted(halt), .o_irq_service(srv), .o_coproc_busy(busy),
        .o_strap_pullup_en(pull));
    // The clock runs at 100 MHz.
    initial forever #5 i_clk = ~i_clk;
    // Outputs are judged at the falling edge, when they have settled.
    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic summarize();
        if (err_total == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Init cycle with strap a at release and b after, then expect mode e.
    task automatic ini(input logic a, b, f, e);
        int n;
        @(posedge i_clk);
        {fb_en, drv_en, drv_val, fire} <= {f, 1'b1, a, 1'b1};
        @(posedge i_clk);
        fire <= 1'b0;
        tk(8);
        chk(dorm & sinit, 1'b1);
        for (n = 0; n < 20 && init_n !== 1'b1; n++) tk(1);
        chk(init_n, 1'b1);
        repeat (2) @(posedge i_clk);
        drv_val <= b;
        for (n = 0; n < 30 && fetch !== 1'b1; n++) tk(1);
        chk(n >= 11 && n <= 17, 1'b1);
        tk(1);
        chk(mode, e);
        chk(dorm, 1'b0);
    endtask
    task automatic modes();
        ini(1'b0, 1'b0, 1'b0, 1'b0);
        ini(1'b0, 1'b1, 1'b0, 1'b0);
        ini(1'b1, 1'b1, 1'b0, 1'b0);
        ini(1'b1, 1'b0, 1'b0, 1'b1);
        ini(1'b1, 1'b1, 1'b1, 1'b1);
    endtask
    task automatic poll();
        ini(1'b0, 1'b1, 1'b0, 1'b0);
        @(posedge i_clk);
        {i_irq_pending, i_irq_enable} <= 2'h3;
        tk(6);
        chk(srv, 1'b0);
        @(posedge i_clk);
        i_wait_start <= 1'b1;
        @(posedge i_clk);
        i_wait_start <= 1'b0;
        tk(3);
        chk(halt & srv, 1'b1);
        @(posedge i_clk);
        drv_val <= 1'b0;
        tk(2);
        chk(halt, 1'b1);
        tk(10);
        chk(halt, 1'b0);
    endtask
    task automatic coproc();
        logic s;
        ini(1'b1, 1'b0, 1'b0, 1'b1);
        @(posedge i_clk);
        {drv_val, i_wait_start} <= 2'h3;
        @(posedge i_clk);
        i_wait_start <= 1'b0;
        tk(6);
        chk(busy & ~halt & pull, 1'b1);
        s = sclk;
        tk(1);
        chk(sclk, ~s);
        @(posedge i_clk);
        drv_val <= 1'b0;
        tk(6);
        chk(busy, 1'b0);
    endtask
    // Main sequence after three cycles of reset.
    initial
    begin
        repeat (3) @(posedge i_clk);
        {i_rst_n, fire} <= 2'h2;
        modes();
        poll();
        coproc();
        summarize();
    end
    // The run needs under 600 clocks; stop a hang well past that.
    initial
    begin
        repeat (3000) @(posedge i_clk);
        err_total++;
        summarize();
    end
endmodule // test_reset_and_mode_select
`default_nettype wire

/* rtl/rms_sync3.v */
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree.
module rms_sync3
#(
    // Level that every stage holds in reset.
    parameter [0:0] INIT_VAL = 1'b1
)
(
    // Clock and reset.
    input wire i_clk,
    input wire i_rst_n,
    // Asynchronous input and filtered result.
    input wire i_async,
    output reg o_sync
);
    reg s1;
    reg s2;
    reg s3;

    // Stage one feeds only stage two.
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s1 <= INIT_VAL;
            s2 <= INIT_VAL;
            s3 <= INIT_VAL;
            o_sync <= INIT_VAL;
        end
        else
        begin
            s1 <= i_async;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                o_sync <= s3;
        end
    end
endmodule // rms_sync3
`default_nettype wire

/* rtl/rms_top.v */
`include "rms_regs.vh"
`default_nettype none
module rms_top
(
    // Oscillator clock and power-on reset.
    input wire i_clk,
    input wire i_rst_n,
    // External hardware init request, active low, asynchronous.
    input wire i_hw_init_request_n,
    // Shared strap, poll and coprocessor-busy pin.
    input wire i_strap_pin,
    // Core handshake for the halt-until-low instruction.
    input wire i_wait_start,
    input wire i_irq_pending,
    input wire i_irq_enable,
    // Outputs.
    output reg o_system_clock_output,
    output reg o_sys_init,
    output reg o_core_dormant,
    output reg o_fetch_start,
    output reg o_mode_enhanced,
    output reg o_wait_halted,
    output reg o_irq_service,
    output reg o_coproc_busy,
    output reg o_strap_pullup_en
);
    wire init_n;
    wire strap;
    reg init_n_d;
    reg [7:0] fetch_cnt;
    reg [3:0] tail_cnt;
    reg [3:0] strap_cnt;
    reg strap_first;
    reg strap_busy;
    reg [3:0] poll_cnt;
    reg tail_busy;

    ///////////////////////////////////////////////////////////////////////////
    // Synchronisers for the pin inputs.
    // Init rests at its active level, so no false rise follows reset.
    rms_sync3
    #(
        .INIT_VAL(1'b0)
    )
    u_init_sync
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_hw_init_request_n),
        .o_sync(init_n)
    );

    // The strap rests high, as the pull-up holds it.
    rms_sync3
    #(
        .INIT_VAL(1'b1)
    )
    u_strap_sync
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_strap_pin),
        .o_sync(strap)
    );

    ///////////////////////////////////////////////////////////////////////////
    // Clock output toggles freely, held low only in reset; it counts as the divider.
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_system_clock_output <= 1'b0;
        else
            o_system_clock_output <= ~o_system_clock_output;
    end

    // The enable marks each rising edge of the clock output.
    wire cyc_en = ~o_system_clock_output;
    wire rise = init_n & ~init_n_d;

    ///////////////////////////////////////////////////////////////////////////
    // Init tracking, init output tail, fetch delay and dormant state.
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            init_n_d <= 1'b0;
            o_sys_init <= 1'b1;
            tail_busy <= 1'b0;
            tail_cnt <= 4'h0;
            fetch_cnt <= 8'h00;
            o_core_dormant <= 1'b1;
            o_fetch_start <= 1'b0;
        end
        else
        begin
            init_n_d <= init_n;
            o_fetch_start <= 1'b0;
            if (!init_n)
            begin
                // Abort at once and stay dormant while held.
                o_core_dormant <= 1'b1;
                o_sys_init <= 1'b1;
                tail_busy <= 1'b0;
                fetch_cnt <= 8'h00;
            end
            else
            begin
                // The synchroniser has already spent part of both delays,
                // so both counts start with that span taken off; otherwise
                // a fed-back init output outlasts the second strap sample.
                if (rise)
                begin
                    tail_busy <= 1'b1;
                    tail_cnt <= `RMS_SYNC_CYC;
                    fetch_cnt <= `RMS_FETCH_DELAY_HALF - `RMS_SYNC_HALF;
                end
                else if (tail_busy)
                begin
                    if (tail_cnt >= `RMS_INIT_TAIL_CYC)
                    begin
                        tail_busy <= 1'b0;
                        o_sys_init <= 1'b0;
                    end
                    else if (cyc_en)
                        tail_cnt <= tail_cnt + 4'h1;
                end
                // One count per oscillator edge, half a system cycle each.
                if (!rise && fetch_cnt != 8'h00)
                begin
                    fetch_cnt <= fetch_cnt - 8'h01;
                    if (fetch_cnt == 8'h01)
                    begin
                        o_fetch_start <= 1'b1;
                        o_core_dormant <= 1'b0;
                    end
                end
            end
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // Strap sampling; the first sample is taken at release, the second
    // four output cycles on. Feeding the init output back gives high then
    // low, so that wiring lands in enhanced mode.
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            strap_first <= 1'b0;
            strap_busy <= 1'b0;
            strap_cnt <= 4'h0;
            o_mode_enhanced <= `RMS_MODE_COMPAT;
            o_strap_pullup_en <= 1'b1;
        end
        else
        begin
            o_strap_pullup_en <= 1'b1;
            if (!init_n)
            begin
                strap_busy <= 1'b0;
                o_mode_enhanced <= `RMS_MODE_COMPAT;
            end
            else if (rise)
            begin
                strap_first <= strap;
                strap_busy <= 1'b1;
                strap_cnt <= 4'h0;
            end
            else if (strap_busy && cyc_en)
            begin
                if (strap_cnt == `RMS_STRAP_CYC - 4'h1)
                begin
                    strap_busy <= 1'b0;
                    // Latched here and held until next init.
                    o_mode_enhanced <= strap_first & ~strap;
                end
                strap_cnt <= strap_cnt + 4'h1;
            end
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // Poll wait in compatible mode, busy input in enhanced mode.
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_wait_halted <= 1'b0;
            poll_cnt <= 4'h0;
            o_irq_service <= 1'b0;
            o_coproc_busy <= 1'b0;
        end
        else
        begin
            o_coproc_busy <= o_mode_enhanced & strap & init_n;
            o_irq_service <= o_wait_halted & i_irq_pending
                & i_irq_enable;
            if (!init_n || o_mode_enhanced)
            begin
                o_wait_halted <= 1'b0;
                poll_cnt <= 4'h0;
            end
            else if (i_wait_start && !o_wait_halted)
            begin
                o_wait_halted <= strap;
                poll_cnt <= 4'h0;
            end
            else if (o_wait_halted)
            begin
                // Resampled only every fifth clock.
                if (poll_cnt == `RMS_POLL_CYC - 4'h1)
                begin
                    poll_cnt <= 4'h0;
                    o_wait_halted <= strap;
                end
                else
                    poll_cnt <= poll_cnt + 4'h1;
            end
        end
    end
endmodule // rms_top
`default_nettype wire

/* shared/rms_regs.vh */
`ifndef RMS_REGS_VH
`define RMS_REGS_VH
// Fetch delay after init release, in half clock-output cycles (6.5 cycles).
`define RMS_FETCH_DELAY_HALF 8'h0D
// Clock-output cycles from init release to end of init output.
`define RMS_INIT_TAIL_CYC 4'h2
// Oscillator clocks from a clean init release to the internal rise.
`define RMS_SYNC_HALF 8'h04
// The same span in clock-output cycles; it counts toward the init tail.
`define RMS_SYNC_CYC 4'h2
// Clock-output cycles from init release to second strap sample.
`define RMS_STRAP_CYC 4'h4
// Oscillator clocks between poll input resamples.
`define RMS_POLL_CYC 4'h5
// Mode encodings.
`define RMS_MODE_COMPAT 1'b0
`define RMS_MODE_ENH 1'b1
`endif
